// File: src/xrl_logic_array.sv
`timescale 1ns/1ps
`default_nettype none
module xrl_logic_array #(
  parameter int NUM_REG = xrl_pkg::DEFAULT_NUM_REG,
  parameter bit LAST_TWO_NO_FB = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [xrl_pkg::NUM_FUSES-1:0] fuse_map,
  input wire logic security_fuse,
  input wire logic [xrl_pkg::DED_INPUTS-1:0] ded_in,
  input wire logic out_enable_n,
  input wire logic preload_pulse_level,
  input wire logic [xrl_pkg::NUM_OUTS-1:0] pin_in,
  output logic [xrl_pkg::NUM_OUTS-1:0] pin_out,
  output logic [xrl_pkg::NUM_OUTS-1:0] pin_oe,
  output logic verify_allowed
);
  import xrl_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NUM_OUTS-1:0] q;
    logic pl_prev;
  } xrl_state_t;

  xrl_state_t st_r;
  xrl_state_t st_nxt;

  xrl_array_if aif();
  logic [NUM_OUTS-1:0] sum3;
  logic [NUM_OUTS-1:0] d_in;
  logic [NUM_OUTS-1:0] term_en;
  logic [NUM_OUTS-1:0] is_reg;
  logic [NUM_INPUTS-DED_INPUTS-1:0] fb_lines;

  // ------------------------------------------------------------
  // array
  // ------------------------------------------------------------
  xrl_and_array #(.N_IN(NUM_INPUTS), .N_TERM(NUM_TERMS)) u_and (
    .fuse_map(fuse_map),
    .arr(aif.array)
  );

  function automatic logic out_is_reg(input int idx);
    // registered outputs sit in the middle of the pin row
    int lo;
    lo = (NUM_OUTS - NUM_REG) / 2;
    return (idx >= lo) && (idx < lo + NUM_REG);
  endfunction : out_is_reg

  always_comb begin
    for (int o = 0; o < NUM_OUTS; o++) begin
      is_reg[o] = out_is_reg(o);
    end
  end

  // feedback: register q for registered pins, pin level otherwise, or 0 for pins 1 and 8 under LAST_TWO_NO_FB with no registers.
  // only 8 feedback lines fit, so the two outermost outputs have none.
  always_comb begin
    for (int k = 0; k < NUM_INPUTS - DED_INPUTS; k++) begin
      if (is_reg[k+1]) begin
        fb_lines[k] = st_r.q[k+1];
      end else if (LAST_TWO_NO_FB && NUM_REG == 0 &&
                   (k == 0 || k == NUM_INPUTS - DED_INPUTS - 1)) begin
        fb_lines[k] = 1'b0;
      end else begin
        fb_lines[k] = pin_in[k+1];
      end
    end
  end

  assign aif.lines = {fb_lines, ded_in};

  // ------------------------------------------------------------
  // output logic
  // ------------------------------------------------------------
  always_comb begin
    for (int o = 0; o < NUM_OUTS; o++) begin
      sum3[o] = |aif.terms[o*TERMS_PER_GROUP +: 3];
      term_en[o] = aif.terms[o*TERMS_PER_GROUP + 3];
      d_in[o] = (aif.terms[o*TERMS_PER_GROUP] |
                 aif.terms[o*TERMS_PER_GROUP+1]) ^
                (aif.terms[o*TERMS_PER_GROUP+2] |
                 aif.terms[o*TERMS_PER_GROUP+3]);
    end
  end

  always_comb begin
    for (int o = 0; o < NUM_OUTS; o++) begin
      if (is_reg[o]) begin
        pin_out[o] = ~st_r.q[o];
        pin_oe[o] = ~out_enable_n;
      end else begin
        pin_out[o] = ~sum3[o];
        pin_oe[o] = term_en[o];
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // preload is modelled on the rising edge of the pulse level; the
  // real part loads asynchronously, but a clocked catch keeps one domain
  always_comb begin
    st_nxt = st_r;
    st_nxt.pl_prev = preload_pulse_level;
    for (int o = 0; o < NUM_OUTS; o++) begin
      if (is_reg[o]) begin
        if (preload_pulse_level && !st_r.pl_prev) begin
          st_nxt.q[o] = ~pin_in[o];
        end else if (!preload_pulse_level) begin
          st_nxt.q[o] = d_in[o];
        end
      end else begin
        st_nxt.q[o] = REG_RESET_VAL;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign verify_allowed = ~security_fuse;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // the middle output is registered in every variant but the all-comb
  // and single-register ones, so most register checks watch it and fall silent there
  localparam int MID = NUM_OUTS / 2;
  localparam int MID_T = MID * TERMS_PER_GROUP;
  localparam int FW = 2 * NUM_INPUTS;

  a_reset_clears: assert property (@(posedge clk)
    rst |=>
      (st_r.q == '0))
    else $error("registers not cleared by reset");

  a_reset_pins: assert property (@(posedge clk)
    rst |=>
      ((pin_out | ~is_reg) == '1))
    else $error("registered pins not high after reset");

  a_reg_capture: assert property (@(posedge clk) disable iff (rst)
    (!preload_pulse_level && is_reg[MID]) |=>
      st_r.q[MID] == $past(d_in[MID]))
    else $error("register missed its d input");

  a_xor_sum: assert property (@(posedge clk) disable iff (rst)
    (!preload_pulse_level && is_reg[MID]) |=>
      st_r.q[MID] == $past((aif.terms[MID_T] | aif.terms[MID_T+1]) ^
                           (aif.terms[MID_T+2] | aif.terms[MID_T+3])))
    else $error("xor of sums wrong");

  a_disabled_run: assert property (@(posedge clk) disable iff (rst)
    (out_enable_n && !preload_pulse_level && is_reg[MID]) |=>
      st_r.q[MID] == $past(d_in[MID]))
    else $error("register stalled while outputs disabled");

  a_oe_shared: assert property (@(posedge clk) disable iff (rst)
    (NUM_REG > 0 && is_reg[MID]) |->
      pin_oe[MID] == !out_enable_n)
    else $error("registered enable wrong");

  a_reg_oe_all: assert property (@(posedge clk) disable iff (rst)
    1'b1 |->
      (pin_oe & is_reg) == (is_reg & {NUM_OUTS{!out_enable_n}}))
    else $error("registered enables differ");

  a_comb_enable: assert property (@(posedge clk) disable iff (rst)
    !is_reg[0] |->
      (pin_oe[0] == aif.terms[3] && pin_out[0] == !(|aif.terms[2:0])))
    else $error("combinatorial output wrong");

  a_comb_sum: assert property (@(posedge clk) disable iff (rst)
    !is_reg[1] |->
      pin_out[1] == !(|aif.terms[TERMS_PER_GROUP +: 3]))
    else $error("combinatorial sum wrong");

  a_comb_unprog: assert property (@(posedge clk) disable iff (rst)
    (!is_reg[1] && !aif.terms[TERMS_PER_GROUP+3]) |->
      !pin_oe[1])
    else $error("unprogrammed output driven");

  a_comb_feedback: assert property (@(posedge clk) disable iff (rst)
    (!is_reg[1] && !(LAST_TWO_NO_FB && NUM_REG == 0)) |->
      aif.lines[DED_INPUTS] == pin_in[1])
    else $error("pin feedback wrong");

  a_comb_q_low: assert property (@(posedge clk) disable iff (rst)
    1'b1 |->
      (st_r.q & ~is_reg) == '0)
    else $error("combinatorial slot holds state");

  a_reg_count: assert property (@(posedge clk) disable iff (rst)
    1'b1 |->
      $countones(is_reg) == NUM_REG)
    else $error("registered output count wrong");

  a_preload_load: assert property (@(posedge clk) disable iff (rst)
    (preload_pulse_level && !st_r.pl_prev && is_reg[MID]) |=>
      st_r.q[MID] == !$past(pin_in[MID]))
    else $error("preload level not loaded");

  a_preload_hold: assert property (@(posedge clk) disable iff (rst)
    (preload_pulse_level && st_r.pl_prev) |=>
      (st_r.q & is_reg) == $past(st_r.q & is_reg))
    else $error("registers moved during preload pulse");

  a_preload_secure: assert property (@(posedge clk) disable iff (rst)
    (security_fuse && preload_pulse_level && !st_r.pl_prev &&
     is_reg[MID]) |=>
      st_r.q[MID] == !$past(pin_in[MID]))
    else $error("security fuse blocked preload");

  a_verify_lock: assert property (@(posedge clk) disable iff (rst)
    1'b1 |->
      verify_allowed == !security_fuse)
    else $error("verify permission wrong");

  a_out_invert: assert property (@(posedge clk) disable iff (rst)
    is_reg[MID] |->
      pin_out[MID] == !st_r.q[MID])
    else $error("registered output not inverted");

  a_fb_internal: assert property (@(posedge clk) disable iff (rst)
    is_reg[MID] |->
      aif.lines[DED_INPUTS+MID-1] == st_r.q[MID])
    else $error("register feedback not internal");

  a_ded_lines: assert property (@(posedge clk) disable iff (rst)
    1'b1 |->
      aif.lines[DED_INPUTS-1:0] == ded_in)
    else $error("dedicated inputs misrouted");

  a_fuse_static: assert property (@(posedge clk) disable iff (rst)
    1'b1 |->
      $stable(fuse_map))
    else $error("fuse map changed in operation");

  a_term_empty: assert property (@(posedge clk) disable iff (rst)
    (fuse_map[3*FW +: FW] == '0) |->
      aif.terms[3])
    else $error("untied term not true");

  a_term_both: assert property (@(posedge clk) disable iff (rst)
    (fuse_map[FW] && fuse_map[FW+1]) |->
      !aif.terms[1])
    else $error("term with both phases not false");

  a_term_single: assert property (@(posedge clk) disable iff (rst)
    (fuse_map[1:0] == 2'b01 && fuse_map[FW-1:2] == '0) |->
      aif.terms[0] == ded_in[0])
    else $error("single tie does not follow its line");

  // ------------------------------------------------------------
  // cover points
  // ------------------------------------------------------------
  c_preload: cover property (@(posedge clk) disable iff (rst)
    preload_pulse_level && !st_r.pl_prev);
  c_disabled_run: cover property (@(posedge clk) disable iff (rst)
    out_enable_n && (st_nxt.q != st_r.q));
  c_comb_on: cover property (@(posedge clk) disable iff (rst)
    !is_reg[0] && pin_oe[0]);
  c_secure_preload: cover property (@(posedge clk) disable iff (rst)
    security_fuse && preload_pulse_level && !st_r.pl_prev);
  c_reset_exit: cover property (@(posedge clk)
    $fell(rst));
endmodule : xrl_logic_array
`default_nettype wire

// File: src/xrl_pkg.sv
package xrl_pkg;
  // ------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------
  localparam int NUM_INPUTS = 20;
  localparam int NUM_TERMS = 40;
  localparam int NUM_FUSES = NUM_INPUTS * 2 * NUM_TERMS;
  localparam int NUM_OUTS = 10;
  localparam int TERMS_PER_GROUP = 4;
  localparam int DEFAULT_NUM_REG = 4;
  localparam int DED_INPUTS = 12;
  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic REG_RESET_VAL = 1'b0;
  localparam int CLK_PERIOD_NS = 10;
  localparam int POWER_UP_SETTLE_TIME_NS = 1000;
  localparam int POWER_UP_SETTLE_CYCLES =
    (POWER_UP_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRELOAD_MIN_GAP_NS = 100;
  localparam int PRELOAD_MIN_GAP_CYCLES =
    (PRELOAD_MIN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : xrl_pkg

// File: src/xrl_array_if.sv
`timescale 1ns/1ps
`default_nettype none
interface xrl_array_if;
  logic [xrl_pkg::NUM_INPUTS-1:0] lines;
  logic [xrl_pkg::NUM_TERMS-1:0] terms;
  modport array (input lines, output terms);
  modport user (output lines, input terms);
endinterface : xrl_array_if
`default_nettype wire

// File: src/xrl_and_array.sv
`timescale 1ns/1ps
`default_nettype none
module xrl_and_array #(
  parameter int N_IN = xrl_pkg::NUM_INPUTS,
  parameter int N_TERM = xrl_pkg::NUM_TERMS
) (
  input wire logic [N_IN*2*N_TERM-1:0] fuse_map,
  xrl_array_if.array arr
);
  import xrl_pkg::*;

  // fuse bit 1 = intact connection; per term: true phase at 2i, comp 2i+1
  function automatic logic term_eval(input logic [2*N_IN-1:0] f,
                                     input logic [N_IN-1:0] x);
    logic t;
    t = 1'b1;
    for (int i = 0; i < N_IN; i++) begin
      if (f[2*i] && !x[i]) t = 1'b0;
      if (f[2*i+1] && x[i]) t = 1'b0;
    end
    return t;
  endfunction : term_eval

  always_comb begin
    for (int p = 0; p < N_TERM; p++) begin
      arr.terms[p] = term_eval(fuse_map[p*2*N_IN +: 2*N_IN], arr.lines);
    end
  end
endmodule : xrl_and_array
`default_nettype wire

// File: bench/xrl_board.sv
`timescale 1ns/1ps
`default_nettype none
module xrl_board (
  input wire logic [xrl_pkg::NUM_OUTS-1:0] out_v,
  input wire logic [xrl_pkg::NUM_OUTS-1:0] oe,
  input wire logic [xrl_pkg::NUM_OUTS-1:0] drv_en,
  input wire logic [xrl_pkg::NUM_OUTS-1:0] drv_val,
  output logic [xrl_pkg::NUM_OUTS-1:0] pin_lvl
);
  import xrl_pkg::*;
  // ----------------------------------------
  // pin wire resolution
  // ----------------------------------------
  // a pin nobody drives reads high through the board pull-up
  always_comb begin
    for (int o = 0; o < NUM_OUTS; o++) begin
      pin_lvl[o] = oe[o] ? out_v[o] : (drv_en[o] ? drv_val[o] : 1'b1);
    end
  end
endmodule : xrl_board
`default_nettype wire

// File: bench/xor_registered_logic_array_bench.sv
`timescale 1ns/1ps
`default_nettype none
module xor_registered_logic_array_bench;
  import xrl_pkg::*;
  logic clk, rst, sec, oen, pre, va;
  logic [NUM_FUSES-1:0] fmap;
  logic [DED_INPUTS-1:0] din;
  logic [NUM_OUTS-1:0] pout, poe, pin, den, dval;
  logic prev;
  int failures, compares;
  // row: {din[11], oen, din[2:0], pin0 expected, pin3 expected}
  logic [6:0] rows [8] = '{7'h03, 7'h45, 7'h0a, 7'h5d,
                           7'h72, 7'h34, 7'h6c, 7'h23};

  xrl_logic_array i_dut (.clk(clk), .rst(rst), .fuse_map(fmap),
    .security_fuse(sec), .ded_in(din), .out_enable_n(oen),
    .preload_pulse_level(pre), .pin_in(pin), .pin_out(pout),
    .pin_oe(poe), .verify_allowed(va));
  xrl_board i_board (.out_v(pout), .oe(poe), .drv_en(den),
    .drv_val(dval), .pin_lvl(pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cmp(input logic [NUM_OUTS-1:0] got, exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // clear a term, then optionally tie one line in true phase
  function automatic void term(input int p, input int i);
    fmap[p*2*NUM_INPUTS +: 2*NUM_INPUTS] = '0;
    if (i >= 0) fmap[p*2*NUM_INPUTS + 2*i] = 1'b1;
  endfunction : term

  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    fmap = '1;
    term(0, 0);
    term(3, -1);
    term(12, 1);
    term(14, 2);
    term(16, 14);
    rst = 1'b1;
    sec = 1'b0;
    oen = 1'b0;
    pre = 1'b0;
    din = '0;
    den = '0;
    dval = '0;
    prev = 1'b1;
    failures = 0;
    compares = 0;
    step(4);
    rst = 1'b0;
    cmp({6'h0, pout[6:3]}, 10'h00f);
    cmp(poe, 10'h079);
    $display("test reset done");
    // pin4 follows the previous pin3 through feedback, also when disabled
    foreach (rows[k]) begin
      din = {rows[k][6], 8'h00, rows[k][4:2]};
      oen = rows[k][5];
      step(1);
      cmp({5'h0, va, pout[4], poe[0], pout[3], pout[0]},
          {5'h1, prev, 1'b1, rows[k][0], rows[k][1]});
      cmp(poe, {3'h0, {4{~rows[k][5]}}, 3'h1});
      prev = rows[k][0];
    end
    $display("test table done");
    // preload with the security fuse blown
    sec = 1'b1;
    oen = 1'b1;
    step(10);
    den = 10'h078;
    dval = 10'h050;
    step(10);
    pre = 1'b1;
    step(10);
    cmp({6'h0, pout[6:3]}, 10'h00a);
    cmp({9'h0, va}, 10'h000);
    cmp(poe & 10'h078, 10'h000);
    pre = 1'b0;
    step(10);
    den = '0;
    step(10);
    oen = 1'b0;
    $display("test preload done");
    rst = 1'b1;
    step(1);
    rst = 1'b0;
    cmp({6'h0, pout[6:3]}, 10'h00f);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : xor_registered_logic_array_bench
`default_nettype wire
